/* File: pdl_pkg.sv */
// shared constants and types for the panel display and level timer block
package pdl_pkg;
    // ********************************************************************
    // clock and timebase
    // ********************************************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam longint unsigned SECOND_PS = 64'd1000000000000;
    localparam int unsigned TICK_CYCLES   = int'(SECOND_PS / CLK_PERIOD_PS);
    localparam int PRESC_W = 28;

    // ********************************************************************
    // register map
    // ********************************************************************
    localparam logic [7:0] ADDR_COLOR   = 8'h00;
    localparam logic [7:0] ADDR_RETURN  = 8'h04;
    localparam logic [7:0] ADDR_PROTECT = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_EDIT    = 8'h10;

    // ********************************************************************
    // setting limits, reset values and hold times
    // ********************************************************************
    localparam logic [1:0]  COLOR_RST    = 2'h0;
    localparam logic [6:0]  RETURN_RST   = 7'h00;
    localparam logic [6:0]  RETURN_MAX   = 7'h63;
    localparam logic [4:0]  PROTECT_RST  = 5'h05;
    localparam logic [4:0]  PROTECT_MAX  = 5'h13;
    localparam logic [4:0]  PROTECT_MIN  = 5'h01;
    localparam logic [4:0]  HOLD_ENTER_S = 5'h03;
    localparam logic [4:0]  HOLD_BACK_S  = 5'h01;
    localparam logic [4:0]  HOLD_MAX     = 5'h1f;
    localparam logic [6:0]  IDLE_MAX     = 7'h7f;
    localparam logic [15:0] PASSWORD     = 16'hff57;

    // ********************************************************************
    // key bits and parameter indices
    // ********************************************************************
    localparam int KEY_LEVEL = 0;
    localparam int KEY_MODE  = 1;
    localparam int KEY_SHIFT = 2;
    localparam int KEY_UP    = 3;
    localparam int KEY_DOWN  = 4;
    localparam logic [4:0] KEYS_LEVEL   = 5'h01;
    localparam logic [4:0] KEYS_PROTECT = 5'h03;

    localparam logic [1:0] PAR_PASSWORD = 2'h0;
    localparam logic [1:0] PAR_COLOR    = 2'h1;
    localparam logic [1:0] PAR_RETURN   = 2'h2;
    localparam logic [1:0] PAR_PROTECT  = 2'h3;

    typedef enum logic [1:0] {
        COL_GREEN_RED = 2'h0,
        COL_GREEN     = 2'h1,
        COL_RED_GREEN = 2'h2,
        COL_RED       = 2'h3
    } pdl_color_e;

    typedef enum logic [1:0] {
        LVL_OPER = 2'h0,
        LVL_INIT = 2'h1,
        LVL_ADV  = 2'h3,
        LVL_PROT = 2'h2
    } pdl_level_e;

    typedef enum logic [1:0] {
        ED_NAME   = 2'h0,
        ED_VALUE  = 2'h1,
        ED_CHANGE = 2'h3,
        ED_SAVE   = 2'h2
    } pdl_edit_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pdl_bus_s;

    typedef struct packed {
        logic       red;
        logic       green;
        logic       blink;
        logic       current_view;
        logic [1:0] level;
    } pdl_view_s;
endpackage : pdl_pkg

/* File: pdl_panel.sv */
// front panel control: indicator colour, level moves, key timers, setting edit
`timescale 1ns/1ps
// Notes on behaviour
// - colour green-to-red shows green, red while comparative output is active
// - colour fixed green always shows green
// - colour red-to-green shows red, green while comparative output is active
// - colour fixed red always shows red
// - auto-return time zero disables inactivity return entirely
// - after 1-99 idle seconds, return to current-value display at operation level
// - auto-return during editing stores the value first, then returns
// - level and mode keys held for protect time at operation level enter protect level
// - a protect time of zero is timed as one second
// - level key held three seconds at operation enters initial setting level
// - advanced level entered only by committing the fixed password value
// - first shift shows set value, second shift enters blinking change state
// - mode key in change state stores the value and advances parameter
// - level key held one second steps back one level
module pdl_panel #(
    parameter int unsigned TICK_CYCLES = pdl_pkg::TICK_CYCLES
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    input  wire logic [4:0]  KEYS,
    input  wire logic        CMP_ACTIVE,
    output logic             IND_RED,
    output logic             IND_GREEN,
    output logic             VALUE_BLINK,
    output logic             CURRENT_VIEW,
    output logic [1:0]       LEVEL,
    output logic [1:0]       PARAM_SEL,
    output logic [15:0]      EDIT_VALUE,
    output logic             STORE_PULSE
);
    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        pdl_pkg::pdl_level_e               level;
        pdl_pkg::pdl_edit_e                edit;
        logic [1:0]                        param;
        logic [15:0]                       value;
        logic                              return_after;
        pdl_pkg::pdl_color_e               color;
        logic [6:0]                        ret_s;
        logic [4:0]                        prot_s;
        logic [pdl_pkg::PRESC_W-1:0]       presc;
        logic [6:0]                        idle_s;
        logic [4:0]                        hold_s;
        logic                              hold_done;
        logic [4:0]                        keys_prev;
        logic [31:0]                       rdata;
        pdl_pkg::pdl_view_s                view;
    } pdl_state_s;

    pdl_state_s st_r;
    pdl_state_s st_nxt;
    pdl_pkg::pdl_bus_s bus;

    logic       tick;
    logic       key_change;
    logic [4:0] key_press;
    logic [4:0] prot_eff;
    logic       idle_fire;
    logic [4:0] hold_goal;
    logic       hold_hit;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // ********************************************************************
    // timebase and key timing
    // ********************************************************************
    // prescaler restarts on every key change so that holds are timed from the press
    assign tick       = st_r.presc == pdl_pkg::PRESC_W'(TICK_CYCLES - 1);
    assign key_change = KEYS != st_r.keys_prev;
    assign key_press  = KEYS & ~st_r.keys_prev;
    assign prot_eff   = (st_r.prot_s == 5'h00) ? pdl_pkg::PROTECT_MIN : st_r.prot_s;
    assign idle_fire  = (st_r.ret_s != 7'h00) && (st_r.idle_s >= st_r.ret_s)
                        && ((st_r.level != pdl_pkg::LVL_OPER)
                            || (st_r.edit != pdl_pkg::ED_NAME));

    always_comb begin
        hold_goal = pdl_pkg::HOLD_MAX;
        if (KEYS == pdl_pkg::KEYS_PROTECT && st_r.level == pdl_pkg::LVL_OPER) begin
            hold_goal = prot_eff;
        end else if (KEYS == pdl_pkg::KEYS_LEVEL) begin
            hold_goal = (st_r.level == pdl_pkg::LVL_OPER) ? pdl_pkg::HOLD_ENTER_S
                                                           : pdl_pkg::HOLD_BACK_S;
        end
    end

    // only a level or protect chord has a goal; a long idle spell with no keys must not move
    assign hold_hit = !st_r.hold_done && !key_change && (hold_goal != pdl_pkg::HOLD_MAX)
                      && (st_r.hold_s >= hold_goal);

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.keys_prev = KEYS;
        st_nxt.presc = (key_change || tick) ? '0 : st_r.presc + 1'b1;

        if (key_press != 5'h00) begin
            st_nxt.idle_s = 7'h00;
        end else if (tick && st_r.idle_s != pdl_pkg::IDLE_MAX) begin
            st_nxt.idle_s = st_r.idle_s + 7'h01;
        end

        if (key_change) begin
            st_nxt.hold_s    = 5'h00;
            st_nxt.hold_done = 1'b0;
        end else if (tick && st_r.hold_s != pdl_pkg::HOLD_MAX) begin
            st_nxt.hold_s = st_r.hold_s + 5'h01;
        end

        // register writes from software
        if (bus.wr) begin
            unique case (bus.addr)
                pdl_pkg::ADDR_COLOR:   st_nxt.color  = pdl_pkg::pdl_color_e'(bus.wdata[1:0]);
                pdl_pkg::ADDR_RETURN:  st_nxt.ret_s  = bus.wdata[6:0];
                pdl_pkg::ADDR_PROTECT: st_nxt.prot_s = bus.wdata[4:0];
                default: ;
            endcase
        end

        // level moves by key hold
        if (hold_hit && st_r.edit != pdl_pkg::ED_SAVE) begin
            st_nxt.hold_done = 1'b1;
            st_nxt.edit      = pdl_pkg::ED_NAME;
            if (KEYS == pdl_pkg::KEYS_PROTECT) begin
                st_nxt.level = pdl_pkg::LVL_PROT;
            end else begin
                unique case (st_r.level)
                    pdl_pkg::LVL_OPER: begin
                        st_nxt.level = pdl_pkg::LVL_INIT;
                        st_nxt.param = pdl_pkg::PAR_PASSWORD;
                    end
                    pdl_pkg::LVL_INIT: st_nxt.level = pdl_pkg::LVL_OPER;
                    pdl_pkg::LVL_ADV: begin
                        st_nxt.level = pdl_pkg::LVL_INIT;
                        st_nxt.param = pdl_pkg::PAR_PASSWORD;
                    end
                    pdl_pkg::LVL_PROT: st_nxt.level = pdl_pkg::LVL_OPER;
                endcase
            end
        end else if (idle_fire && st_r.edit == pdl_pkg::ED_CHANGE) begin
            st_nxt.edit         = pdl_pkg::ED_SAVE;
            st_nxt.return_after = 1'b1;
        end else if (idle_fire && st_r.edit != pdl_pkg::ED_SAVE) begin
            st_nxt.level = pdl_pkg::LVL_OPER;
            st_nxt.edit  = pdl_pkg::ED_NAME;
        end else if (st_r.level == pdl_pkg::LVL_INIT || st_r.level == pdl_pkg::LVL_ADV) begin
            unique case (st_r.edit)
                pdl_pkg::ED_NAME: begin
                    if (key_press[pdl_pkg::KEY_SHIFT]) begin
                        st_nxt.edit = pdl_pkg::ED_VALUE;
                        unique case (st_r.param)
                            pdl_pkg::PAR_COLOR:   st_nxt.value = {14'h0000, st_r.color};
                            pdl_pkg::PAR_RETURN:  st_nxt.value = {9'h000, st_r.ret_s};
                            pdl_pkg::PAR_PROTECT: st_nxt.value = {11'h000, st_r.prot_s};
                            default:              st_nxt.value = 16'h0000;
                        endcase
                    end else if (key_press[pdl_pkg::KEY_MODE]) begin
                        st_nxt.param = next_param(st_r.param);
                    end
                end
                pdl_pkg::ED_VALUE: begin
                    if (key_press[pdl_pkg::KEY_SHIFT]) begin
                        st_nxt.edit = pdl_pkg::ED_CHANGE;
                    end else if (key_press[pdl_pkg::KEY_MODE]) begin
                        st_nxt.edit  = pdl_pkg::ED_NAME;
                        st_nxt.param = next_param(st_r.param);
                    end
                end
                pdl_pkg::ED_CHANGE: begin
                    if (key_press[pdl_pkg::KEY_MODE]) begin
                        st_nxt.edit = pdl_pkg::ED_SAVE;
                    end else if (key_press[pdl_pkg::KEY_UP]) begin
                        st_nxt.value = st_r.value + 16'h0001;
                    end else if (key_press[pdl_pkg::KEY_DOWN]) begin
                        st_nxt.value = st_r.value - 16'h0001;
                    end
                end
                pdl_pkg::ED_SAVE: begin
                    st_nxt.edit  = pdl_pkg::ED_NAME;
                    st_nxt.param = next_param(st_r.param);
                    // out-of-range return and protect entries saturate rather than wrap; colour keeps value bits 1:0
                    unique case (st_r.param)
                        pdl_pkg::PAR_COLOR: st_nxt.color = pdl_pkg::pdl_color_e'(st_r.value[1:0]);
                        pdl_pkg::PAR_RETURN: st_nxt.ret_s =
                            (st_r.value > {9'h000, pdl_pkg::RETURN_MAX}) ? pdl_pkg::RETURN_MAX
                                                                          : st_r.value[6:0];
                        pdl_pkg::PAR_PROTECT: st_nxt.prot_s =
                            (st_r.value > {11'h000, pdl_pkg::PROTECT_MAX}) ? pdl_pkg::PROTECT_MAX
                                                                            : st_r.value[4:0];
                        pdl_pkg::PAR_PASSWORD: begin
                            st_nxt.param = pdl_pkg::PAR_PASSWORD;
                            if (st_r.value == pdl_pkg::PASSWORD) begin
                                st_nxt.level = pdl_pkg::LVL_ADV;
                                st_nxt.param = pdl_pkg::PAR_COLOR;
                            end
                        end
                    endcase
                    if (st_r.return_after) begin
                        st_nxt.level        = pdl_pkg::LVL_OPER;
                        st_nxt.return_after = 1'b0;
                    end
                end
            endcase
        end

        // read data stands in the cycle after the strobe only
        st_nxt.rdata = 32'h0000_0000;
        if (bus.rd) begin
            unique case (bus.addr)
                pdl_pkg::ADDR_COLOR:   st_nxt.rdata = {30'h0, st_r.color};
                pdl_pkg::ADDR_RETURN:  st_nxt.rdata = {25'h0, st_r.ret_s};
                pdl_pkg::ADDR_PROTECT: st_nxt.rdata = {27'h0, st_r.prot_s};
                pdl_pkg::ADDR_STATUS:  st_nxt.rdata = {24'h0, st_r.param, st_r.edit,
                                                      st_r.level, st_r.view.red,
                                                      st_r.view.green};
                pdl_pkg::ADDR_EDIT:    st_nxt.rdata = {16'h0, st_r.value};
                default:               st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // indicator colour follows the setting and comparison result
        unique case (st_r.color)
            pdl_pkg::COL_GREEN_RED: st_nxt.view.red = CMP_ACTIVE;
            pdl_pkg::COL_GREEN:     st_nxt.view.red = 1'b0;
            pdl_pkg::COL_RED_GREEN: st_nxt.view.red = !CMP_ACTIVE;
            pdl_pkg::COL_RED:       st_nxt.view.red = 1'b1;
        endcase
        st_nxt.view.green        = !st_nxt.view.red;
        st_nxt.view.blink        = st_nxt.edit == pdl_pkg::ED_CHANGE;
        st_nxt.view.current_view = st_nxt.level == pdl_pkg::LVL_OPER;
        st_nxt.view.level        = st_nxt.level;
    end

    function automatic logic [1:0] next_param(input logic [1:0] p);
        // advanced parameters wrap; the initial level holds the password entry only
        next_param = (p == pdl_pkg::PAR_PROTECT) ? pdl_pkg::PAR_COLOR
                   : (p == pdl_pkg::PAR_PASSWORD) ? pdl_pkg::PAR_PASSWORD : p + 2'h1;
    endfunction : next_param

    // ********************************************************************
    // registers
    // ********************************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_r        <= '0;
            st_r.color  <= pdl_pkg::pdl_color_e'(pdl_pkg::COLOR_RST);
            st_r.ret_s  <= pdl_pkg::RETURN_RST;
            st_r.prot_s <= pdl_pkg::PROTECT_RST;
            st_r.view.green        <= 1'b1;
            st_r.view.current_view <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign RDATA        = st_r.rdata;
    assign IND_RED      = st_r.view.red;
    assign IND_GREEN    = st_r.view.green;
    assign VALUE_BLINK  = st_r.view.blink;
    assign CURRENT_VIEW = st_r.view.current_view;
    assign LEVEL        = st_r.view.level;
    assign PARAM_SEL    = st_r.param;
    assign EDIT_VALUE   = st_r.value;
    assign STORE_PULSE  = st_r.edit == pdl_pkg::ED_SAVE;
endmodule : pdl_panel

/* File: pdl_panel_monitor.sv */
// port checker for the panel block, bound into the design
`timescale 1ns/1ps
module pdl_panel_monitor (
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [4:0]  KEYS,
    input wire logic        IND_RED,
    input wire logic        IND_GREEN,
    input wire logic        VALUE_BLINK,
    input wire logic        CURRENT_VIEW,
    input wire logic [1:0]  LEVEL,
    input wire logic [15:0] EDIT_VALUE,
    input wire logic        STORE_PULSE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // ********************
    // sequences
    // ********************
    sequence mode_in_change;
        VALUE_BLINK && KEYS[pdl_pkg::KEY_MODE] && !$past(KEYS[pdl_pkg::KEY_MODE]);
    endsequence
    sequence enter_adv;
        LEVEL == pdl_pkg::LVL_ADV && $past(LEVEL) != pdl_pkg::LVL_ADV;
    endsequence
    sequence enter_prot;
        LEVEL == pdl_pkg::LVL_PROT && $past(LEVEL) != pdl_pkg::LVL_PROT;
    endsequence
    // ********************
    // assertions
    // ********************
    ind_one_colour_a: assert property (IND_GREEN != IND_RED)
        else $error("indicator shows both or neither colour");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside the answer cycle");
    store_single_a: assert property (STORE_PULSE |=> !STORE_PULSE)
        else $error("store pulse longer than one cycle");
    store_no_blink_a: assert property (STORE_PULSE |-> !VALUE_BLINK)
        else $error("value still blinking while stored");
    mode_commits_a: assert property (mode_in_change |-> ##[1:2] STORE_PULSE)
        else $error("mode key in change state did not store");
    blink_in_setting_a: assert property (VALUE_BLINK |->
        LEVEL == pdl_pkg::LVL_INIT || LEVEL == pdl_pkg::LVL_ADV)
        else $error("change state outside setting levels");
    view_at_oper_a: assert property (CURRENT_VIEW |-> LEVEL == pdl_pkg::LVL_OPER)
        else $error("current value shown away from operation level");
    prot_by_hold_a: assert property (enter_prot |->
        $past(LEVEL) == pdl_pkg::LVL_OPER && $past(KEYS) == pdl_pkg::KEYS_PROTECT)
        else $error("protect level entered without key hold");
    adv_by_password_a: assert property (enter_adv |->
        $past(STORE_PULSE) && $past(EDIT_VALUE) == pdl_pkg::PASSWORD)
        else $error("advanced level entered without password");
endmodule : pdl_panel_monitor

bind pdl_panel pdl_panel_monitor u_mon (
    .MCLK(MCLK), .RST_N(RST_N), .RD(RD), .RDATA(RDATA), .KEYS(KEYS),
    .IND_RED(IND_RED), .IND_GREEN(IND_GREEN), .VALUE_BLINK(VALUE_BLINK),
    .CURRENT_VIEW(CURRENT_VIEW), .LEVEL(LEVEL), .EDIT_VALUE(EDIT_VALUE),
    .STORE_PULSE(STORE_PULSE)
);

/* File: pdl_keys.sv */
// model of the operator keys on the front panel
`timescale 1ns/1ps
module pdl_keys (
    input wire logic  MCLK,
    output logic [4:0] KEYS
);
    // ********************
    // key actions
    // ********************
    initial KEYS = 5'h00;
    // held until the next call; the caller times the hold
    task automatic hold_keys(input logic [4:0] v);
        @(posedge MCLK);
        KEYS <= v;
    endtask : hold_keys
    // two quiet cycles after release so the edit step has landed
    task automatic press(input int idx);
        @(posedge MCLK);
        KEYS <= 5'(1 << idx);
        @(posedge MCLK);
        KEYS <= 5'h00;
        repeat (2) @(posedge MCLK);
        #1;
    endtask : press
endmodule : pdl_keys

/* File: pdl_panel_bench.sv */
// self-checking bench for the panel block with its key model
`timescale 1ns/1ps
module pdl_panel_bench;
    localparam int T = 16;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cmp = 1'b0;
    logic [31:0] rdata;
    logic [4:0]  keys;
    logic        ind_red;
    logic        blink;
    logic        cur_view;
    logic        store;
    logic [1:0]  level;
    logic [1:0]  par_sel;
    logic [15:0] edit_val;
    int          err_count = 0;
    int          tests_run = 0;

    always #2.5 mclk = ~mclk;

    pdl_keys u_keys (.MCLK(mclk), .KEYS(keys));
    pdl_panel #(.TICK_CYCLES(T)) u_dut (
        .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .KEYS(keys), .CMP_ACTIVE(cmp), .IND_RED(ind_red),
        .IND_GREEN(), .VALUE_BLINK(blink), .CURRENT_VIEW(cur_view), .LEVEL(level),
        .PARAM_SEL(par_sel), .EDIT_VALUE(edit_val), .STORE_PULSE(store)
    );
    // ********************
    // helpers
    // ********************
    function automatic logic exp_red(input logic [1:0] c, input logic a);
        case (c)
            pdl_pkg::COL_GREEN_RED: return a;
            pdl_pkg::COL_GREEN:     return 1'b0;
            pdl_pkg::COL_RED_GREEN: return !a;
            default:                return 1'b1;
        endcase
    endfunction : exp_red
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd
    task automatic wait_lvl(input logic [1:0] e, input int n);
        for (int i = 0; i < n && level !== e; i++) @(posedge mclk) #1;
        check({30'h0, level}, {30'h0, e});
    endtask : wait_lvl
    // level must not move early, then must move within a few cycles
    task automatic hold_move(input logic [4:0] k, input int n, input logic [1:0] e);
        logic [1:0] was;
        was = level;
        u_keys.hold_keys(k);
        repeat (n - 1) @(posedge mclk);
        #1 check({30'h0, level}, {30'h0, was});
        wait_lvl(e, 8);
        u_keys.hold_keys(5'h00);
    endtask : hold_move
    task automatic enter_val(input logic [15:0] v);
        u_keys.press(pdl_pkg::KEY_SHIFT);
        u_keys.press(pdl_pkg::KEY_SHIFT);
        for (int i = 0; i < 400 && edit_val !== v; i++) u_keys.press(pdl_pkg::KEY_DOWN);
        u_keys.press(pdl_pkg::KEY_MODE);
    endtask : enter_val
    // ********************
    // main sequence
    // ********************
    initial begin
        logic [31:0] d;
        logic [1:0]  c;
        logic        a;
        logic [4:0]  p;
        void'($urandom(84333));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        bus_rd(pdl_pkg::ADDR_PROTECT, d);
        check(d, 32'h5);
        bus_rd(8'h14, d);
        check(d, 32'h0);
        for (int i = 0; i < 16; i++) begin
            {c, a} = (i < 8) ? i[2:0] : 3'($urandom);
            cmp <= a;
            bus_wr(pdl_pkg::ADDR_COLOR, {30'h0, c});
            repeat (2) @(posedge mclk);
            #1 check({31'h0, ind_red}, {31'h0, exp_red(c, a)});
        end
        hold_move(pdl_pkg::KEYS_LEVEL, 3 * T, pdl_pkg::LVL_INIT);
        repeat (12 * T) @(posedge mclk);
        #1 check({30'h0, level}, {30'h0, pdl_pkg::LVL_INIT});
        enter_val(pdl_pkg::PASSWORD + 16'h1);
        repeat (3) @(posedge mclk);
        #1 check({30'h0, level}, {30'h0, pdl_pkg::LVL_INIT});
        enter_val(pdl_pkg::PASSWORD);
        wait_lvl(pdl_pkg::LVL_ADV, 4);
        check({30'h0, par_sel}, {30'h0, pdl_pkg::PAR_COLOR});
        u_keys.press(pdl_pkg::KEY_SHIFT);
        check({15'h0, blink, edit_val}, {30'h0, c});
        u_keys.press(pdl_pkg::KEY_SHIFT);
        check({31'h0, blink}, 32'h1);
        u_keys.press(pdl_pkg::KEY_UP);
        check({16'h0, edit_val}, {30'h0, c} + 32'h1);
        u_keys.press(pdl_pkg::KEY_MODE);
        @(posedge mclk) #1 check({30'h0, par_sel}, {30'h0, pdl_pkg::PAR_RETURN});
        bus_rd(pdl_pkg::ADDR_COLOR, d);
        check(d, {30'h0, c + 2'h1});
        hold_move(pdl_pkg::KEYS_LEVEL, T, pdl_pkg::LVL_INIT);
        hold_move(pdl_pkg::KEYS_LEVEL, T, pdl_pkg::LVL_OPER);
        for (int j = 0; j < 3; j++) begin
            p = 5'(2 * j);
            bus_wr(pdl_pkg::ADDR_PROTECT, {27'h0, p});
            hold_move(pdl_pkg::KEYS_PROTECT, T * ((p == 5'h0) ? 1 : int'(p)),
                      pdl_pkg::LVL_PROT);
            hold_move(pdl_pkg::KEYS_LEVEL, T, pdl_pkg::LVL_OPER);
        end
        // return time set only after the presses, so idle starts near zero
        hold_move(pdl_pkg::KEYS_LEVEL, 3 * T, pdl_pkg::LVL_INIT);
        u_keys.press(pdl_pkg::KEY_SHIFT);
        u_keys.press(pdl_pkg::KEY_SHIFT);
        bus_wr(pdl_pkg::ADDR_RETURN, 32'h2);
        repeat (T) @(posedge mclk);
        #1 check({31'h0, blink}, 32'h1);
        for (int i = 0; i < 3 * T && store !== 1'b1; i++) @(posedge mclk) #1;
        check({31'h0, store}, 32'h1);
        wait_lvl(pdl_pkg::LVL_OPER, 4);
        check({31'h0, cur_view}, 32'h1);
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
endmodule : pdl_panel_bench
